// file: design/lane_status_pkg.sv
// Constants shared by the lane status monitor and its error counters.
// Assumes the APB slave sits on a 16-bit byte address, 32-bit data.

package lane_status_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_LINKS = 2;   // Links selectable by the page
  localparam int NUM_LANES = 2;   // Lanes covered: lane 2 and lane 3
  localparam int ERR_TYPES = 3;   // Disparity, invalid, unexpected
  localparam int CNT_W     = 8;   // Counter and threshold width
  localparam int ADDR_W    = 16;  // APB byte address width
  localparam int DATA_W    = 32;  // APB data width
  localparam int IDX_W     = 14;  // Word index width
  localparam int IRQ_W     = 3;   // Interrupt status width
  localparam int SYNC_W    = 5;   // Lane 2 synchronisation levels

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_LINK_PAGE    = 14'h0300;
  localparam logic [IDX_W-1:0] IDX_LANE2_STATUS = 14'h04B2;
  localparam logic [IDX_W-1:0] IDX_LANE3_STATUS = 14'h04B3;
  localparam logic [IDX_W-1:0] IDX_ERR_THRESH   = 14'h0310;
  localparam logic [IDX_W-1:0] IDX_CNT_CTRL     = 14'h0311;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS   = 14'h0320;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK     = 14'h0321;

  // ----------------------------------------------------------------
  // Lane status byte layout
  // ----------------------------------------------------------------
  localparam int BIT_DISP   = 7;
  localparam int BIT_NIT    = 6;
  localparam int BIT_UEK    = 5;
  localparam int BIT_DESKEW = 4;
  localparam int BIT_ILA    = 3;
  localparam int BIT_CKSUM  = 2;
  localparam int BIT_FRAME  = 1;
  localparam int BIT_CGS    = 0;

  // Error type slots within one lane
  localparam int ERR_DISP = 0;
  localparam int ERR_NIT  = 1;
  localparam int ERR_UEK  = 2;

  // Interrupt status layout
  localparam int IRQ_THRESH     = 0;
  localparam int IRQ_SYNC_LOST  = 1;
  localparam int IRQ_ALIGN_LOST = 2;

  // Control register layout
  localparam int CTRL_CLR = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0]  THRESH_RST = 8'hFF;
  localparam logic [CNT_W-1:0]  PAGE_RST   = 8'h00;
  localparam logic [IRQ_W-1:0]  IRQ_RST    = 3'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;

endpackage

// file: design/lane_err_counter.sv
// One saturating error counter with its threshold flag.
// Assumes increments and clears come from logic on the same clock.

module lane_err_counter
  import lane_status_pkg::*;
#(
  parameter int CW = CNT_W
) (
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          arst_n_i,
  // Control
  input  wire logic          clr_i,
  input  wire logic          inc_i,
  input  wire logic [CW-1:0] thresh_i,
  // Result
  output logic      [CW-1:0] count_o,
  output logic               flag_o
);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          flag;
  } cnt_state_t;

  localparam logic [CW-1:0] CNT_MAX = {CW{1'b1}};
  localparam logic [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};

  cnt_state_t st_reg;
  cnt_state_t st_next;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Count one per event and stop at the top so it never wraps
  always_comb begin
    st_next = st_reg;
    if (clr_i) begin
      st_next.count = '0;
    end else if (inc_i && (st_reg.count != CNT_MAX)) begin
      st_next.count = st_reg.count + CNT_ONE;
    end
    st_next.flag = (st_next.count >= thresh_i);
  end

  // State register, zero out of reset
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign count_o = st_reg.count;
  assign flag_o  = st_reg.flag;

endmodule

// file: design/lane_status_monitor.sv
// Lane status monitor: error thresholds and lane 2/3 status bytes.
// Assumes lane events and levels come from decoder logic on sys_clk_i
// and software reaches the registers through an APB slave port.
//
// Operation
// - Lane 2 bit 7: disparity count at threshold
// - Lane 2 bit 6: invalid symbol count at threshold
// - Lane 2 bit 5: unexpected control count at threshold
// - Lane 2 bit 4: interlane deskew achieved
// - Lane 2 bit 3: initial lane alignment achieved
// - Lane 2 bit 2: configuration checksum correct
// - Lane 2 bit 1: frame alignment held
// - Lane 2 bit 0: code group sync achieved
// - Lane 3 bits 7..5: three threshold flags
// - Status reads follow the selected link page
// - Flag is count at or above threshold

module lane_status_monitor
  import lane_status_pkg::*;
#(
  parameter int                LINKS      = NUM_LINKS,
  parameter logic [CNT_W-1:0]  THRESH_DEF = THRESH_RST
) (
  // Clock and reset
  input  wire logic                               sys_clk_i,
  input  wire logic                               arst_n_i,
  // APB slave
  input  wire logic [ADDR_W-1:0]                  paddr_i,
  input  wire logic                               psel_i,
  input  wire logic                               penable_i,
  input  wire logic                               pwrite_i,
  input  wire logic [DATA_W-1:0]                  pwdata_i,
  input  wire logic [3:0]                         pstrb_i,
  output logic      [DATA_W-1:0]                  prdata_o,
  output logic                                    pready_o,
  output logic                                    pslverr_o,
  // Decoder error events, one cycle each, [link][lane 2/3]
  input  wire logic [LINKS-1:0][NUM_LANES-1:0]    disp_err_i,
  input  wire logic [LINKS-1:0][NUM_LANES-1:0]    invalid_sym_i,
  input  wire logic [LINKS-1:0][NUM_LANES-1:0]    unexp_ctrl_i,
  // Lane 2 synchronisation levels, per link
  input  wire logic [LINKS-1:0]                   lane2_codegroup_sync_i,
  input  wire logic [LINKS-1:0]                   lane2_frame_sync_i,
  input  wire logic [LINKS-1:0]                   lane2_config_sum_i,
  input  wire logic [LINKS-1:0]                   lane2_initial_align_i,
  input  wire logic [LINKS-1:0]                   lane2_deskew_i,
  // Interrupt
  output logic                                    irq_o
);

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  // Number of error counters in the block
  localparam int NCNT = LINKS * NUM_LANES * ERR_TYPES;

  // Every register of the block except the error counters lives in this one struct
  typedef struct packed {
    logic [CNT_W-1:0]            page;
    logic [CNT_W-1:0]            thresh;
    logic                        clr;
    logic [IRQ_W-1:0]            irq_stat;
    logic [IRQ_W-1:0]            irq_mask;
    logic [DATA_W-1:0]           rdata;
    logic [LINKS-1:0][SYNC_W-1:0] sync;
    logic [NCNT-1:0]             flag_prev;
    logic                        irq;
  } mon_state_t;

  mon_state_t st_reg;
  mon_state_t st_next;

  // Counter hookup, flattened as ((link*lanes)+lane)*types+type
  logic [NCNT-1:0] ev_vec;
  logic [NCNT-1:0] flag_vec;

  // Bus decode
  logic [IDX_W-1:0] idx;
  logic             setup_ph;
  logic             access_ph;
  logic             hit;
  logic             hit_ro;

  // ----------------------------------------------------------------
  // Error counters
  // ----------------------------------------------------------------
  // One counter per link, lane and error type
  // Counters saturate, so a noisy lane never wraps its flag off
  for (genvar g = 0; g < NCNT; g++) begin : g_cnt
    // Slot number decoded back to link, lane and type
    localparam int LK = g / (NUM_LANES * ERR_TYPES);
    localparam int LN = (g / ERR_TYPES) % NUM_LANES;
    localparam int TY = g % ERR_TYPES;

    // Pick the event line for this slot
    if (TY == ERR_DISP) begin : g_disp
      assign ev_vec[g] = disp_err_i[LK][LN];
    end else if (TY == ERR_NIT) begin : g_nit
      assign ev_vec[g] = invalid_sym_i[LK][LN];
    end else begin : g_uek
      assign ev_vec[g] = unexp_ctrl_i[LK][LN];
    end

    lane_err_counter #(
      .CW       (CNT_W)
    ) u_cnt (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .clr_i     (st_reg.clr),
      .inc_i     (ev_vec[g]),
      .thresh_i  (st_reg.thresh),
      .count_o   (),
      .flag_o    (flag_vec[g])
    );
  end

  // ----------------------------------------------------------------
  // Status byte assembly
  // ----------------------------------------------------------------
  // Build the status byte of one lane of one link
  function automatic logic [CNT_W-1:0] lane_byte(
    input logic [NCNT-1:0]              flags,
    input logic [LINKS-1:0][SYNC_W-1:0] sync,
    input logic [CNT_W-1:0]             page,
    input int                           lane
  );
    logic [CNT_W-1:0] b;
    int               base;
    b    = '0;
    base = 0;
    // Pages past the last link read as zero
    if (int'(page) < LINKS) begin
      base = (int'(page) * NUM_LANES + lane) * ERR_TYPES;
      // Both lanes carry the three threshold flags
      b[BIT_DISP] = flags[base + ERR_DISP];
      b[BIT_NIT]  = flags[base + ERR_NIT];
      b[BIT_UEK]  = flags[base + ERR_UEK];
      // Synchronisation levels are kept for lane 2 only
      if (lane == 0) begin
        b[BIT_DESKEW] = sync[page][BIT_DESKEW];
        b[BIT_ILA]    = sync[page][BIT_ILA];
        b[BIT_CKSUM]  = sync[page][BIT_CKSUM];
        b[BIT_FRAME]  = sync[page][BIT_FRAME];
        b[BIT_CGS]    = sync[page][BIT_CGS];
      end
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Word index and phase qualifiers
  // Address bits 1:0 are ignored; every register is one word
  assign idx       = paddr_i[ADDR_W-1:2];
  assign setup_ph  = psel_i && !penable_i;
  assign access_ph = psel_i && penable_i;

  // Address map; status bytes refuse writes
  // Unmapped indices answer with pslverr and read as zero
  always_comb begin
    hit    = 1'b0;
    hit_ro = 1'b0;
    case (idx)
      IDX_LINK_PAGE,
      IDX_ERR_THRESH,
      IDX_CNT_CTRL,
      IDX_IRQ_MASK: begin
        hit = 1'b1;
      end
      IDX_LANE2_STATUS,
      IDX_LANE3_STATUS,
      IDX_IRQ_STATUS: begin
        hit    = 1'b1;
        hit_ro = 1'b1;
      end
      default: begin
        hit    = 1'b0;
        hit_ro = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [IRQ_W-1:0]  evt;
    logic [IRQ_W-1:0]  rd_clr;
    logic [DATA_W-1:0] rd;
    logic              wr_ok;
    evt    = '0;
    rd_clr = '0;
    rd     = DATA_ZERO;
    wr_ok  = 1'b0;
    st_next = st_reg;
    // Counter clear is a one-cycle strobe
    st_next.clr = 1'b0;

    // Sample the lane 2 synchronisation levels of every link
    for (int l = 0; l < LINKS; l++) begin
      st_next.sync[l][BIT_CGS]    = lane2_codegroup_sync_i[l];
      st_next.sync[l][BIT_FRAME]  = lane2_frame_sync_i[l];
      st_next.sync[l][BIT_CKSUM]  = lane2_config_sum_i[l];
      st_next.sync[l][BIT_ILA]    = lane2_initial_align_i[l];
      st_next.sync[l][BIT_DESKEW] = lane2_deskew_i[l];
      // Loss compares the level held one cycle earlier
      // Falling sync, frame, alignment or deskew levels raise loss events
      if ((st_reg.sync[l][BIT_CGS] && !lane2_codegroup_sync_i[l]) ||
          (st_reg.sync[l][BIT_FRAME] && !lane2_frame_sync_i[l])) begin
        evt[IRQ_SYNC_LOST] = 1'b1;
      end
      if ((st_reg.sync[l][BIT_ILA] && !lane2_initial_align_i[l]) ||
          (st_reg.sync[l][BIT_DESKEW] && !lane2_deskew_i[l])) begin
        evt[IRQ_ALIGN_LOST] = 1'b1;
      end
    end

    // A flag crossing its threshold raises an event
    // History and flags both reset to zero: no false edge
    evt[IRQ_THRESH]   = |(flag_vec & ~st_reg.flag_prev);
    st_next.flag_prev = flag_vec;

    // Read data are captured in the setup phase
    // so prdata_o is a flop and a read-clear drops only what was seen
    case (idx)
      IDX_LINK_PAGE:    rd[CNT_W-1:0] = st_reg.page;
      IDX_ERR_THRESH:   rd[CNT_W-1:0] = st_reg.thresh;
      IDX_IRQ_STATUS:   rd[IRQ_W-1:0] = st_reg.irq_stat;
      IDX_IRQ_MASK:     rd[IRQ_W-1:0] = st_reg.irq_mask;
      IDX_CNT_CTRL:     rd = DATA_ZERO;  // Clear is a strobe
      IDX_LANE2_STATUS: begin
        rd[CNT_W-1:0] = lane_byte(flag_vec, st_reg.sync,
                                  st_reg.page, 0);
      end
      IDX_LANE3_STATUS: begin
        rd[CNT_W-1:0] = lane_byte(flag_vec, st_reg.sync,
                                  st_reg.page, 1);
      end
      default:          rd = DATA_ZERO;
    endcase
    if (setup_ph && !pwrite_i) begin
      st_next.rdata = rd;
    end

    // Writes land at the access edge, low byte lane only
    // Read-only and unmapped targets never change state
    wr_ok = access_ph && pwrite_i && hit && !hit_ro && pstrb_i[0];
    if (wr_ok) begin
      case (idx)
        IDX_LINK_PAGE:  st_next.page     = pwdata_i[CNT_W-1:0];
        IDX_ERR_THRESH: st_next.thresh   = pwdata_i[CNT_W-1:0];
        IDX_CNT_CTRL:   st_next.clr      = pwdata_i[CTRL_CLR];
        IDX_IRQ_MASK:   st_next.irq_mask = pwdata_i[IRQ_W-1:0];
        default:        st_next.clr      = 1'b0;
      endcase
    end

    // Reading status clears only the bits that were returned
    if (access_ph && !pwrite_i && (idx == IDX_IRQ_STATUS)) begin
      rd_clr = st_reg.rdata[IRQ_W-1:0];
    end
    // A new event in the clearing cycle survives
    st_next.irq_stat = (st_reg.irq_stat & ~rd_clr) | evt;
    // Interrupt level is registered so irq_o comes from a flop
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Everything comes out of reset at zero except the threshold
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg.clr       <= 1'b0;
      st_reg.sync      <= '0;
      st_reg.flag_prev <= '0;
      st_reg.irq       <= 1'b0;
      st_reg.page      <= PAGE_RST;
      st_reg.thresh    <= THRESH_DEF;
      st_reg.irq_stat  <= IRQ_RST;
      st_reg.irq_mask  <= IRQ_RST;
      st_reg.rdata     <= DATA_ZERO;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero-wait slave; errors for unmapped or read-only writes
  // A write with pstrb_i[0] low to a writable register is dropped without an error
  assign pready_o  = 1'b1;
  assign pslverr_o = access_ph && (!hit || (pwrite_i && hit_ro));
  assign prdata_o  = st_reg.rdata;

  // Level interrupt while any unmasked status bit is set
  assign irq_o = st_reg.irq;

endmodule

// file: verif/lane_status_props.sv
// Port assertions for the lane status monitor.
// Assumes it is bound into lane_status_monitor.
module lane_status_props
  import lane_status_pkg::*;
#(
  parameter int LINKS = NUM_LINKS
) (
  // Clock, reset and bus
  input wire logic              sys_clk_i,
  input wire logic              arst_n_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  input wire logic [3:0]        pstrb_i,
  input wire logic [DATA_W-1:0] prdata_o,
  input wire logic              pslverr_o,
  // Lane 2 levels
  input wire logic [LINKS-1:0]  lane2_codegroup_sync_i,
  input wire logic [LINKS-1:0]  lane2_frame_sync_i,
  input wire logic [LINKS-1:0]  lane2_config_sum_i,
  input wire logic [LINKS-1:0]  lane2_initial_align_i,
  input wire logic [LINKS-1:0]  lane2_deskew_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [7:0] pg_reg, thr_reg;
  logic [4:0] sync_w;
  logic       wr_w, rd2_w, rd3_w;
  // Decoded bus phases and the selected link's levels
  assign wr_w  = psel_i & penable_i & pwrite_i & pstrb_i[0];
  assign rd2_w = psel_i & !penable_i & !pwrite_i & (paddr_i == 16'h12C8);
  assign rd3_w = psel_i & !penable_i & !pwrite_i & (paddr_i == 16'h12CC);
  assign sync_w = (pg_reg < LINKS) ? {lane2_deskew_i[pg_reg],
    lane2_initial_align_i[pg_reg], lane2_config_sum_i[pg_reg],
    lane2_frame_sync_i[pg_reg], lane2_codegroup_sync_i[pg_reg]} : 5'h00;
  // Shadow of page and threshold from bus writes
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pg_reg  <= 8'h00;
      thr_reg <= 8'hFF;
    end else if (wr_w && paddr_i == 16'h0C00) begin
      pg_reg <= pwdata_i[7:0];
    end else if (wr_w && paddr_i == 16'h0C40) begin
      thr_reg <= pwdata_i[7:0];
    end
  end
  AST_RST_ZERO: assert property (
    $rose(arst_n_i) |-> prdata_o == 32'h0)
    else $error("read data not zero after reset");
  AST_RO_LANE2: assert property (
    wr_w && paddr_i == 16'h12C8 |-> pslverr_o)
    else $error("lane 2 status write not refused");
  AST_RO_LANE3: assert property (
    wr_w && paddr_i == 16'h12CC |-> pslverr_o)
    else $error("lane 3 status write not refused");
  AST_SYNC: assert property (
    rd2_w |=> prdata_o[4:0] == $past(sync_w, 2))
    else $error("lane 2 sync bits wrong");
  AST_L3_LOW: assert property (
    rd3_w |=> prdata_o[4:0] == 5'h00)
    else $error("lane 3 low bits not zero");
  AST_UPPER: assert property (
    rd2_w || rd3_w |=> prdata_o[31:8] == 24'h0)
    else $error("status upper bits not zero");
  AST_OFF_PAGE: assert property (
    (rd2_w || rd3_w) && pg_reg >= LINKS |=> prdata_o == 32'h0)
    else $error("status nonzero on absent link");
  AST_THR_ZERO: assert property (
    rd2_w && pg_reg < LINKS && thr_reg == 8'h00 &&
    $past(thr_reg) == 8'h00 |=> prdata_o[7:5] == 3'h7)
    else $error("zero threshold flags not set");
endmodule

bind lane_status_monitor lane_status_props #(.LINKS(LINKS)) props_u (
  .sys_clk_i, .arst_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i,
  .pwdata_i, .pstrb_i, .prdata_o, .pslverr_o, .lane2_codegroup_sync_i,
  .lane2_frame_sync_i, .lane2_config_sum_i, .lane2_initial_align_i,
  .lane2_deskew_i
);

// file: verif/lane_tx_model.sv
// Transmitter side model: error pulses and lane 2 levels.
// Assumes the bench calls its tasks on the shared clock.
module lane_tx_model (
  // Clock
  input  wire logic       sys_clk_i,
  // Error pulses [link][lane]
  output logic [1:0][1:0] disp_o,
  output logic [1:0][1:0] inv_o,
  output logic [1:0][1:0] unexp_o,
  // Lane 2 levels per link
  output logic [1:0]      cgs_o,
  output logic [1:0]      frm_o,
  output logic [1:0]      sum_o,
  output logic [1:0]      ila_o,
  output logic [1:0]      dsk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0][1:0][1:0] ev_reg  = '0;
  logic [1:0][4:0]      lvl_reg = '0;
  // Outputs from the event and level stores
  assign disp_o  = ev_reg[0];
  assign inv_o   = ev_reg[1];
  assign unexp_o = ev_reg[2];
  assign cgs_o   = {lvl_reg[1][0], lvl_reg[0][0]};
  assign frm_o   = {lvl_reg[1][1], lvl_reg[0][1]};
  assign sum_o   = {lvl_reg[1][2], lvl_reg[0][2]};
  assign ila_o   = {lvl_reg[1][3], lvl_reg[0][3]};
  assign dsk_o   = {lvl_reg[1][4], lvl_reg[0][4]};
  // One-cycle error pulses of type t on link l, lane k
  task automatic burst(input int t, input int l, input int k, input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      ev_reg[t][l][k] <= 1'b1;
      @(posedge sys_clk_i);
      ev_reg[t][l][k] <= 1'b0;
    end
  endtask
  // Sync, alignment and checksum levels of one link
  task automatic set_sync(input int l, input logic [4:0] v);
    @(posedge sys_clk_i);
    lvl_reg[l] <= v;
  endtask
endmodule

// file: verif/serial_lane_status_monitor_tb.sv
// Self-checking bench for the lane status monitor.
// Assumes the transmitter model drives all lane inputs.
module serial_lane_status_monitor_tb
  import lane_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk_i = 1'b0;
  logic              arst_n_i  = 1'b0;
  logic [ADDR_W-1:0] paddr_i   = 16'h0000;
  logic              psel_i    = 1'b0;
  logic              penable_i = 1'b0;
  logic              pwrite_i  = 1'b0;
  logic [DATA_W-1:0] pwdata_i  = 32'h0;
  logic [3:0]        pstrb_i   = 4'hF;
  logic [DATA_W-1:0] prdata_o, rd;
  logic              pready_o, pslverr_o, irq_o, er;
  logic [1:0][1:0]   disp_err_i, invalid_sym_i, unexp_ctrl_i;
  logic [1:0]        lane2_codegroup_sync_i, lane2_frame_sync_i;
  logic [1:0]        lane2_config_sum_i, lane2_initial_align_i;
  logic [1:0]        lane2_deskew_i;
  int                mismatches = 0;
  int                checks     = 0;
  // Clock
  initial forever #5 sys_clk_i = ~sys_clk_i;
  lane_status_monitor dut_u (
    .sys_clk_i, .arst_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i,
    .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
    .disp_err_i, .invalid_sym_i, .unexp_ctrl_i,
    .lane2_codegroup_sync_i, .lane2_frame_sync_i, .lane2_config_sum_i,
    .lane2_initial_align_i, .lane2_deskew_i, .irq_o
  );
  lane_tx_model tx_u (
    .sys_clk_i, .disp_o(disp_err_i), .inv_o(invalid_sym_i),
    .unexp_o(unexp_ctrl_i), .cgs_o(lane2_codegroup_sync_i),
    .frm_o(lane2_frame_sync_i), .sum_o(lane2_config_sum_i),
    .ila_o(lane2_initial_align_i), .dsk_o(lane2_deskew_i)
  );
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      mismatches++;
      finish_test();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic sc_reset;
    rchk(16'h12C8, 32'h0);
    rchk(16'h12CC, 32'h0);
    wr(16'h12C8, 32'hFF);
    chk({31'h0, er}, 32'h1);
    wr(16'h12CC, 32'hFF);
    chk({31'h0, er}, 32'h1);
    rchk(16'h12C8, 32'h0);
    rchk(16'h0004, 32'h0);
    chk({31'h0, er}, 32'h1);
    // Write with byte lane 0 off is dropped without error
    pstrb_i <= 4'hE;
    wr(16'h0C40, 32'h55);
    pstrb_i <= 4'hF;
    chk({31'h0, er}, 32'h0);
    rchk(16'h0C40, 32'hFF);
  endtask
  // Threshold 3: two events leave a flag clear, the third sets it
  task automatic sc_flags;
    logic [7:0] ex [2];
    ex = '{8'h00, 8'h00};
    wr(16'h0C40, 32'h3);
    for (int k = 0; k < 2; k++) begin
      for (int t = 0; t < 3; t++) begin
        tx_u.burst(t, 0, k, 2);
        rchk(16'h12C8 + 16'(4 * k), {24'h0, ex[k]});
        tx_u.burst(t, 0, k, 1);
        ex[k][7 - t] = 1'b1;
        rchk(16'h12C8 + 16'(4 * k), {24'h0, ex[k]});
      end
    end
  endtask
  // Masked, unmasked, then cleared by reading the status
  task automatic sc_irq;
    @(negedge sys_clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(16'h0C84, 32'h7);
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk({31'h0, irq_o}, 32'h1);
    rchk(16'h0C80, 32'h1);
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk({31'h0, irq_o}, 32'h0);
  endtask
  task automatic sc_page;
    tx_u.set_sync(0, 5'h16);
    tx_u.set_sync(1, 5'h09);
    wr(16'h0C00, 32'h1);
    rchk(16'h12C8, 32'h09);
    rchk(16'h12CC, 32'h00);
    wr(16'h0C00, 32'h0);
    rchk(16'h12C8, 32'hF6);
    rchk(16'h12CC, 32'hE0);
    wr(16'h0C00, 32'h2);
    rchk(16'h12C8, 32'h00);
    // Frame and deskew fall on link 0: both loss bits, then cleared
    tx_u.set_sync(0, 5'h00);
    rchk(16'h0C80, 32'h6);
    rchk(16'h0C80, 32'h0);
    tx_u.set_sync(0, 5'h16);
  endtask
  // Counter clear, then thresholds 0 and 1 at their boundaries
  task automatic sc_clear;
    wr(16'h0C00, 32'h0);
    wr(16'h0C44, 32'h1);
    repeat (3) @(posedge sys_clk_i);
    rchk(16'h12C8, 32'h16);
    wr(16'h0C40, 32'h0);
    rchk(16'h12C8, 32'hF6);
    wr(16'h0C40, 32'h1);
    tx_u.burst(1, 0, 1, 1);
    rchk(16'h12CC, 32'h40);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    sc_reset();
    sc_flags();
    sc_irq();
    sc_page();
    sc_clear();
    finish_test();
  end
endmodule
